// ---- hdl/xie_pkg.sv ----
package xie_pkg;
	// special function register addresses
	localparam logic [7:0] XIE_EN_ADDR = 8'hE7;
	localparam logic [7:0] XIE_PRIO_ADDR = 8'hF6;
	// reset values
	localparam logic [7:0] XIE_EN_RST = 8'h00;
	localparam logic [7:0] XIE_PRIO_RST = 8'h00;
	localparam logic [7:0] XIE_RD_NONE = 8'h00;
	// writable bits of the enable register
	localparam logic [7:0] XIE_EN_WMASK = 8'h5F;
	// enable register fields
	localparam int XIE_EN_UNUSED_HI = 7;
	localparam int XIE_EN_UART2 = 6;
	localparam int XIE_EN_UNUSED_LO = 5;
	localparam int XIE_EN_ADC2_CONV = 4;
	localparam int XIE_EN_ADC2_WIN = 3;
	localparam int XIE_EN_TMR4 = 2;
	localparam int XIE_EN_ADC0_CONV = 1;
	localparam int XIE_EN_TMR3 = 0;
	// priority register fields
	localparam int XIE_PR_CMP1_RISE = 7;
	localparam int XIE_PR_CMP1_FALL = 6;
	localparam int XIE_PR_CMP0_RISE = 5;
	localparam int XIE_PR_CMP0_FALL = 4;
	localparam int XIE_PR_CNT_ARRAY = 3;
	localparam int XIE_PR_ADC0_WIN = 2;
	localparam int XIE_PR_TWO_WIRE = 1;
	localparam int XIE_PR_SER_PERIPH = 0;
	// priority level encoding
	localparam logic XIE_LVL_LOW = 1'b0;
	localparam logic XIE_LVL_HIGH = 1'b1;
endpackage

// ---- hdl/xie_gate_if.sv ----
`timescale 1ns/1ps
interface xie_gate_if;
	logic [7:0] en_reg;
	logic [7:0] prio_reg;
	logic [7:0] en_src;
	logic [7:0] pr_src;
	logic [7:0] en_req;
	logic [7:0] hi_req;
	logic [7:0] lo_req;
	modport ctl (
		output en_reg,
		output prio_reg,
		output en_src,
		output pr_src,
		input en_req,
		input hi_req,
		input lo_req
	);
	modport gate (
		input en_reg,
		input prio_reg,
		input en_src,
		input pr_src,
		output en_req,
		output hi_req,
		output lo_req
	);
endinterface

// ---- hdl/xie_gate.sv ----
`timescale 1ns/1ps
module xie_gate
	import xie_pkg::*;
(
	xie_gate_if.gate g
);
	// masking of enable-register sources
	always_comb begin
		g.en_req = g.en_src & g.en_reg & XIE_EN_WMASK;
	end

	// split priority-register sources into two levels
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (g.prio_reg[i] == XIE_LVL_HIGH) begin
				g.hi_req[i] = g.pr_src[i];
				g.lo_req[i] = 1'b0;
			end else begin
				g.hi_req[i] = 1'b0;
				g.lo_req[i] = g.pr_src[i];
			end
		end
	end
endmodule

// ---- hdl/xie_top.sv ----
`timescale 1ns/1ps
module xie_top
	import xie_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// special function register port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// sources masked by the enable register
	input wire logic second_uart_req,
	input wire logic adc2_conv_req,
	input wire logic adc2_win_req,
	input wire logic timer4_req,
	input wire logic adc0_conv_req,
	input wire logic timer3_req,
	// sources ranked by the priority register
	input wire logic comparator_one_rise_req,
	input wire logic comparator_one_fall_req,
	input wire logic comparator_zero_rise_req,
	input wire logic comparator_zero_fall_req,
	input wire logic cnt_array_req,
	input wire logic adc0_win_req,
	input wire logic two_wire_req,
	input wire logic ser_periph_req,
	// outputs toward the core
	output logic [7:0] en_req,
	output logic [7:0] hi_req,
	output logic [7:0] lo_req,
	output logic [7:0] extended_irq_enable_two,
	output logic [7:0] extended_irq_priority_one
);
	logic [7:0] en_q;
	logic [7:0] prio_q;
	logic [7:0] rdata_q;
	logic [7:0] en_req_q;
	logic [7:0] hi_req_q;
	logic [7:0] lo_req_q;
	logic [7:0] en_src;
	logic [7:0] pr_src;

	xie_gate_if gif ();

	xie_gate u_gate (
		.g(gif.gate)
	);

	// pack sources by bit position
	always_comb begin
		en_src = 8'h00;
		en_src[XIE_EN_UART2] = second_uart_req;
		en_src[XIE_EN_ADC2_CONV] = adc2_conv_req;
		en_src[XIE_EN_ADC2_WIN] = adc2_win_req;
		en_src[XIE_EN_TMR4] = timer4_req;
		en_src[XIE_EN_ADC0_CONV] = adc0_conv_req;
		en_src[XIE_EN_TMR3] = timer3_req;
	end

	always_comb begin
		pr_src = 8'h00;
		pr_src[XIE_PR_CMP1_RISE] = comparator_one_rise_req;
		pr_src[XIE_PR_CMP1_FALL] = comparator_one_fall_req;
		pr_src[XIE_PR_CMP0_RISE] = comparator_zero_rise_req;
		pr_src[XIE_PR_CMP0_FALL] = comparator_zero_fall_req;
		pr_src[XIE_PR_CNT_ARRAY] = cnt_array_req;
		pr_src[XIE_PR_ADC0_WIN] = adc0_win_req;
		pr_src[XIE_PR_TWO_WIRE] = two_wire_req;
		pr_src[XIE_PR_SER_PERIPH] = ser_periph_req;
	end

	assign gif.en_reg = en_q;
	assign gif.prio_reg = prio_q;
	assign gif.en_src = en_src;
	assign gif.pr_src = pr_src;

	// enable register
	always_ff @(posedge clock) begin
		if (rst) begin
			en_q <= XIE_EN_RST;
		end else if (sfr_wr && sfr_addr == XIE_EN_ADDR) begin
			en_q <= sfr_wdata & XIE_EN_WMASK;
		end
	end

	// priority register
	always_ff @(posedge clock) begin
		if (rst) begin
			prio_q <= XIE_PRIO_RST;
		end else if (sfr_wr && sfr_addr == XIE_PRIO_ADDR) begin
			prio_q <= sfr_wdata;
		end
	end

	// read data, one cycle after the read strobe
	always_ff @(posedge clock) begin
		if (rst) begin
			rdata_q <= XIE_RD_NONE;
		end else if (sfr_rd) begin
			if (sfr_addr == XIE_EN_ADDR) begin
				rdata_q <= en_q & XIE_EN_WMASK;
			end else if (sfr_addr == XIE_PRIO_ADDR) begin
				rdata_q <= prio_q;
			end else begin
				rdata_q <= XIE_RD_NONE;
			end
		end
	end

	// registered request outputs
	always_ff @(posedge clock) begin
		if (rst) begin
			en_req_q <= 8'h00;
			hi_req_q <= 8'h00;
			lo_req_q <= 8'h00;
		end else begin
			en_req_q <= gif.en_req;
			hi_req_q <= gif.hi_req;
			lo_req_q <= gif.lo_req;
		end
	end

	assign sfr_rdata = rdata_q;
	assign en_req = en_req_q;
	assign hi_req = hi_req_q;
	assign lo_req = lo_req_q;
	assign extended_irq_enable_two = en_q;
	assign extended_irq_priority_one = prio_q;
endmodule

// ---- sim/xie_chk.sv ----
`timescale 1ns/1ps
module xie_chk (
	// watched ports
	input wire logic clock,
	input wire logic rst,
	input wire logic second_uart_req,
	input wire logic comparator_one_fall_req,
	input wire logic comparator_zero_rise_req,
	input wire logic [7:0] en_req,
	input wire logic [7:0] hi_req,
	input wire logic [7:0] lo_req,
	input wire logic [7:0] extended_irq_enable_two,
	input wire logic [7:0] extended_irq_priority_one
);
	wire logic [7:0] ev = extended_irq_enable_two;
	wire logic [7:0] pv = extended_irq_priority_one;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_unused_zero: assert property (
		!(ev[7] | ev[5] | en_req[7] | en_req[5])) else $error("unused bit set");
	a_uart_gate: assert property (
		en_req[6] == $past(ev[6] && second_uart_req && !rst))
		else $error("uart gate");
	a_fall_low: assert property (
		comparator_one_fall_req && !pv[6] |=> lo_req[6] && !hi_req[6])
		else $error("fall not low");
	a_fall_high: assert property (
		comparator_one_fall_req && pv[6] |=> hi_req[6] && !lo_req[6])
		else $error("fall not high");
	a_cmp0_rise: assert property (
		comparator_zero_rise_req |=> hi_req[5] == $past(pv[5]) &&
		lo_req[5] != hi_req[5]) else $error("rise level");
	a_reset_clear: assert property (disable iff (1'b0) rst |=>
		!(ev | pv | en_req | hi_req | lo_req)) else $error("reset not clear");
	c_uart: cover property (en_req[6]);
	c_high: cover property (hi_req[6]);
	c_low: cover property (lo_req[6]);
endmodule
bind xie_top xie_chk i_chk (.*);

// ---- sim/xie_core_model.sv ----
`timescale 1ns/1ps
module xie_core_model (
	// requests from the block
	input wire logic clock,
	input wire logic [7:0] hi_req,
	input wire logic [7:0] lo_req,
	// vector being serviced
	output logic [7:0] srv_q
);
	// high level wins over low
	always_ff @(posedge clock) srv_q <= |hi_req ? hi_req : lo_req;
endmodule

// ---- sim/extended_irq_enable_priority_bench.sv ----
`timescale 1ns/1ps
module extended_irq_enable_priority_bench;
	import xie_pkg::*;
	logic clock = 0, rst = 1, wr = 0, rd = 0;
	logic [7:0] a = 0, d = 0, w, p, q, e, h, l, re, rp, v;
	logic [13:0] s = 0;
	int failures = 0, n_checks = 0;
	xie_top i_dut (.clock(clock), .rst(rst), .sfr_addr(a), .sfr_wr(wr),
		.sfr_rd(rd), .sfr_wdata(d), .sfr_rdata(q), .second_uart_req(s[13]),
		.adc2_conv_req(s[12]), .adc2_win_req(s[11]), .timer4_req(s[10]),
		.adc0_conv_req(s[9]), .timer3_req(s[8]),
		.comparator_one_rise_req(s[7]), .comparator_one_fall_req(s[6]),
		.comparator_zero_rise_req(s[5]), .comparator_zero_fall_req(s[4]),
		.cnt_array_req(s[3]), .adc0_win_req(s[2]), .two_wire_req(s[1]),
		.ser_periph_req(s[0]), .en_req(e), .hi_req(h), .lo_req(l),
		.extended_irq_enable_two(re), .extended_irq_priority_one(rp));
	xie_core_model i_core (.clock(clock), .hi_req(h), .lo_req(l), .srv_q(v));
	task automatic chk(logic [7:0] seen, logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	// one access: write or read, strobe for one cycle
	task automatic acc(logic we, logic [7:0] ad, logic [7:0] da);
		@(negedge clock) {wr, rd, a, d} = {we, !we, ad, da};
		@(negedge clock) {wr, rd} = 2'h0;
	endtask
	function automatic logic [7:0] en_exp(logic [7:0] en, logic [13:0] src);
		return en & 8'h5F & {1'b0, src[13], 1'b0, src[12:8]};
	endfunction
	task final_report;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		forever #5 clock = ~clock;
	end
	initial begin
		#20us;
		failures++;
		final_report();
	end
	initial begin
		w = $urandom(32'hC1150E4C);
		repeat (6) @(negedge clock);
		rst = 0;
		chk(re, XIE_EN_RST);
		chk(rp, XIE_PRIO_RST);
		for (int i = 0; i < 40; i++) begin
			w = i == 0 ? 8'hFF : $urandom;
			p = i == 1 ? 8'hFF : (i == 0 ? 8'h00 : $urandom);
			acc(1, XIE_EN_ADDR, w);
			acc(1, XIE_PRIO_ADDR, p);
			acc(0, XIE_EN_ADDR, 8'h00);
			chk(q, w & XIE_EN_WMASK);
			acc(0, XIE_PRIO_ADDR, 8'h00);
			chk(q, p);
			chk(re, w & XIE_EN_WMASK);
			s = i < 2 ? 14'h3FFF : $urandom;
			@(negedge clock);
			chk(e, en_exp(w, s));
			chk(h, p & s[7:0]);
			chk(l, ~p & s[7:0]);
			@(negedge clock);
			chk(v, |(p & s[7:0]) ? p & s[7:0] : ~p & s[7:0]);
		end
		// unmapped place: write ignored, read gives zero
		acc(1, 8'h00, 8'hFF);
		acc(0, 8'h00, 8'h00);
		chk(q, XIE_RD_NONE);
		chk(rp, p);
		// reset in mid-run clears both registers and all requests
		rst = 1;
		@(negedge clock);
		rst = 0;
		chk(re, XIE_EN_RST);
		chk(rp, XIE_PRIO_RST);
		chk(e, 8'h00);
		chk(h, 8'h00);
		chk(l, 8'h00);
		repeat (2) @(negedge clock);
		final_report();
	end
endmodule
